// ===== hdl/xor_ext_exec.sv
// Execution unit for exclusive-OR with file and the extended instructions, AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module xor_ext_exec
	import xor_ext_pkg::*;
#(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_WIDTH-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_WIDTH-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic busy
);
	// ==========================================================
	// Elaboration check: the map needs eight address bits.
	if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_width
		$error("ADDR_WIDTH must lie between 8 and 32");
	end

	// ==========================================================
	// Architectural state.
	state_t state;
	logic ext_en;
	logic [31:0] instr;
	logic [7:0] acc;
	logic [3:0] bank;
	logic [11:0] ptr [PTR_COUNT];
	logic [20:0] pc;
	logic [20:0] return_stack_top;
	logic [12:0] pc_latch;
	logic zero_flag;
	logic neg_flag;
	logic illegal;
	logic [11:0] mem_addr;
	logic [7:0] mem [DATA_SPACE_BYTES];
	logic [7:0] move_data;

	// Bus side state.
	logic aw_held;
	logic w_held;
	logic [ADDR_WIDTH-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic [31:0] wr_value;

	// Decode results.
	op_t op;
	logic illegal_op;
	logic exec;
	logic second;
	logic two_cycle;
	logic [15:0] word1;
	logic [15:0] word2;
	logic [11:0] file_addr;
	logic [7:0] xor_result;
	logic [11:0] src_addr;
	logic [11:0] dst_addr;

	// ==========================================================
	// Register decode helpers.
	function automatic logic is_reg(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] off);
		return addr == ADDR_WIDTH'(off);
	endfunction

	function automatic logic [31:0] reg_read(input logic [ADDR_WIDTH-1:0] addr);
		logic [31:0] value;
		value = 32'h0000_0000;
		if (is_reg(addr, REG_CTRL)) value[CTRL_EXT_BIT] = ext_en;
		if (is_reg(addr, REG_INSTR)) value = instr;
		if (is_reg(addr, REG_ACC)) value[7:0] = acc;
		if (is_reg(addr, REG_BANK)) value[3:0] = bank;
		for (int i = 0; i < PTR_COUNT; i++) begin
			if (is_reg(addr, REG_PTR0 + 8'(PTR_STRIDE * i))) value[11:0] = ptr[i];
		end
		if (is_reg(addr, REG_PC)) value[20:0] = pc;
		if (is_reg(addr, REG_TOS)) value[20:0] = return_stack_top;
		if (is_reg(addr, REG_PC_LATCH)) value[12:0] = pc_latch;
		if (is_reg(addr, REG_STATUS)) begin
			value[STAT_BUSY_BIT] = busy;
			value[STAT_ZERO_BIT] = zero_flag;
			value[STAT_NEG_BIT] = neg_flag;
			value[STAT_ILLEGAL_BIT] = illegal;
		end
		if (is_reg(addr, REG_MEM_ADDR)) value[11:0] = mem_addr;
		if (is_reg(addr, REG_MEM_DATA)) value[7:0] = mem[mem_addr];
		return value;
	endfunction

	function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] addr);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 13; i++) begin
			if (is_reg(addr, 8'(4 * i))) hit = 1'b1;
		end
		return hit;
	endfunction

	// Pointer plus seven-bit unsigned offset, wrapping in the data space.
	function automatic logic [11:0] index_addr(input logic [11:0] base, input logic [6:0] off);
		return base + {5'h00, off};
	endfunction

	// ==========================================================
	// AXI4-Lite write channels. Address and data are held apart until both are in.
	assign awready = !aw_held;
	assign wready = !w_held;
	// Writes wait while an instruction runs, so the bus never races the datapath.
	assign wr_fire = aw_held && w_held && !bvalid && !busy;

	always_comb begin
		wr_value = reg_read(aw_addr);
		for (int b = 0; b < 4; b++) begin
			if (w_strb[b]) wr_value[8*b +: 8] = w_data[8*b +: 8];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			aw_addr <= awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			w_data <= wdata;
			w_strb <= wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// Write response; unmapped offsets answer with a slave error.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read channel, one outstanding read.
	assign arready = !rvalid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= reg_read(araddr);
			rresp <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Decode and operand addressing.
	assign word1 = instr[15:0];
	assign word2 = instr[31:16];
	assign exec = state == ST_EXEC;
	assign second = state == ST_SECOND;
	assign busy = state != ST_IDLE;

	op_decoder u_decoder (
		.word1(word1),
		.word2(word2),
		.ext_en(ext_en),
		.op(op),
		.illegal(illegal_op)
	);

	// Ops that take a second cycle.
	assign two_cycle = op inside {OP_FRAME_ADD_RET, OP_FRAME_SUB_RET, OP_CALL_ACC,
		OP_MOVE_TO_FILE, OP_MOVE_TO_INDEXED};

	// File operand address for the exclusive-OR.
	always_comb begin
		if (word1[8]) begin
			file_addr = {bank, word1[7:0]};
		end else if (ext_en && word1[7:0] <= INDEX_LIMIT) begin
			// Indexed literal offset from the frame pointer.
			file_addr = index_addr(ptr[FRAME_PTR], word1[6:0]);
		end else if (word1[7:0] >= ACCESS_SPLIT) begin
			// Access bank, upper half maps to the top page.
			file_addr = {ACCESS_HIGH_PAGE, word1[7:0]};
		end else begin
			file_addr = {ACCESS_LOW_PAGE, word1[7:0]};
		end
	end

	assign xor_result = acc ^ mem[file_addr];
	// Source from frame offset, destination literal or offset.
	assign src_addr = index_addr(ptr[FRAME_PTR], word1[6:0]);
	assign dst_addr = word1[7] ? index_addr(ptr[FRAME_PTR], word2[6:0]) : word2[11:0];

	// ==========================================================
	// Sequencer: one cycle per instruction, a second for return, call and moves.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: if (wr_fire && is_reg(aw_addr, REG_INSTR)) state <= ST_EXEC;
				ST_EXEC: state <= two_cycle ? ST_SECOND : ST_IDLE;
				ST_SECOND: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Software-held registers that the datapath only reads.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_en <= CTRL_EXT_RESET;
			instr <= 32'h0000_0000;
			bank <= 4'h0;
			pc_latch <= 13'h0000;
			mem_addr <= 12'h000;
		end else if (wr_fire) begin
			if (is_reg(aw_addr, REG_CTRL)) ext_en <= wr_value[CTRL_EXT_BIT];
			if (is_reg(aw_addr, REG_INSTR)) instr <= wr_value;
			if (is_reg(aw_addr, REG_BANK)) bank <= wr_value[3:0];
			if (is_reg(aw_addr, REG_PC_LATCH)) pc_latch <= wr_value[12:0];
			if (is_reg(aw_addr, REG_MEM_ADDR)) mem_addr <= wr_value[11:0];
		end
	end

	// Accumulator.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc <= ACC_RESET;
		end else if (wr_fire && is_reg(aw_addr, REG_ACC)) begin
			acc <= wr_value[7:0];
		end else if (exec && op == OP_XOR && !word1[9]) begin
			acc <= xor_result;
		end
	end

	// Status flags; extended ops leave them alone.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_flag <= 1'b0;
			neg_flag <= 1'b0;
		end else if (exec && op == OP_XOR) begin
			// Only negative and zero follow the result.
			zero_flag <= xor_result == 8'h00;
			neg_flag <= xor_result[7];
		end
	end

	// Refused word flag, cleared when the next instruction is loaded.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			illegal <= 1'b0;
		end else if (exec && illegal_op) begin
			illegal <= 1'b1;
		end else if (wr_fire && is_reg(aw_addr, REG_INSTR)) begin
			illegal <= 1'b0;
		end
	end

	// ==========================================================
	// Pointer registers, one process each.
	for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
		localparam logic [7:0] PTR_OFF = REG_PTR0 + 8'(PTR_STRIDE * i);
		localparam logic [1:0] SEL = 2'(i);
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				ptr[i] <= PTR_RESET;
			end else if (wr_fire && is_reg(aw_addr, PTR_OFF)) begin
				ptr[i] <= wr_value[11:0];
			end else if (exec) begin
				case (op)
					// Add or subtract the six-bit literal.
					OP_PTR_ADD: if (word1[7:6] == SEL) ptr[i] <= ptr[i] + {6'h00, word1[5:0]};
					OP_PTR_SUB: if (word1[7:6] == SEL) ptr[i] <= ptr[i] - {6'h00, word1[5:0]};
					// Frame pointer only for the returning forms.
					OP_FRAME_ADD_RET: if (i == FRAME_PTR) ptr[i] <= ptr[i] + {6'h00, word1[5:0]};
					OP_FRAME_SUB_RET: if (i == FRAME_PTR) ptr[i] <= ptr[i] - {6'h00, word1[5:0]};
					OP_PUSH: if (i == FRAME_PTR) ptr[i] <= ptr[i] - 12'h001;
					default: ptr[i] <= ptr[i];
				endcase
			end
		end
	end

	// ==========================================================
	// Program counter and return stack top.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= PC_RESET;
			return_stack_top <= PC_RESET;
		end else if (wr_fire) begin
			if (is_reg(aw_addr, REG_PC)) pc <= wr_value[20:0];
			if (is_reg(aw_addr, REG_TOS)) return_stack_top <= wr_value[20:0];
		end else if (exec) begin
			case (op)
				OP_FRAME_ADD_RET, OP_FRAME_SUB_RET: pc <= return_stack_top;
				// Push return address, jump to latch and accumulator.
				OP_CALL_ACC: begin
					return_stack_top <= pc + PC_ONE_WORD;
					pc <= {pc_latch, acc};
				end
				OP_MOVE_TO_FILE, OP_MOVE_TO_INDEXED: pc <= pc + PC_TWO_WORDS;
				default: pc <= pc + PC_ONE_WORD;
			endcase
		end
	end

	// ==========================================================
	// Data space. Only one writer acts per cycle since bus writes wait for idle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			move_data <= 8'h00;
		end else if (exec) begin
			move_data <= mem[src_addr];
		end
	end

	always_ff @(posedge clk) begin
		if (wr_fire && is_reg(aw_addr, REG_MEM_DATA)) begin
			mem[mem_addr] <= wr_value[7:0];
		end else if (exec && op == OP_XOR && word1[9]) begin
			mem[file_addr] <= xor_result;
		end else if (exec && op == OP_PUSH) begin
			// Store literal at the frame pointer.
			mem[ptr[FRAME_PTR]] <= word1[7:0];
		end else if (second && (op == OP_MOVE_TO_FILE || op == OP_MOVE_TO_INDEXED)) begin
			// Second cycle writes the moved byte.
			mem[dst_addr] <= move_data;
		end
	end
endmodule

// ===== inc/xor_ext_pkg.sv
// Constants, types and register map of the exclusive-OR and extended instruction unit.
package xor_ext_pkg;
	// ==========================================================
	// Register map and fields.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INSTR = 8'h04;
	localparam logic [7:0] REG_ACC = 8'h08;
	localparam logic [7:0] REG_BANK = 8'h0c;
	localparam logic [7:0] REG_PTR0 = 8'h10;
	localparam int PTR_STRIDE = 4;
	localparam int PTR_COUNT = 3;
	localparam logic [7:0] REG_PC = 8'h1c;
	localparam logic [7:0] REG_TOS = 8'h20;
	localparam logic [7:0] REG_PC_LATCH = 8'h24;
	localparam logic [7:0] REG_STATUS = 8'h28;
	localparam logic [7:0] REG_MEM_ADDR = 8'h2c;
	localparam logic [7:0] REG_MEM_DATA = 8'h30;
	localparam int CTRL_EXT_BIT = 0;
	localparam logic CTRL_EXT_RESET = 1'b1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ZERO_BIT = 1;
	localparam int STAT_NEG_BIT = 2;
	localparam int STAT_ILLEGAL_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Opcodes and addressing.
	localparam logic [5:0] XOR_PREFIX = 6'h06;
	localparam logic [7:0] OPC_PTR_ADD = 8'he8;
	localparam logic [7:0] OPC_PTR_SUB = 8'he9;
	localparam logic [7:0] OPC_PUSH = 8'hea;
	localparam logic [7:0] OPC_MOVE = 8'heb;
	localparam logic [15:0] OPC_CALL_ACC = 16'h0014;
	localparam logic [3:0] SECOND_WORD_PREFIX = 4'hf;
	localparam logic [1:0] FRAME_SELECT = 2'h3;
	localparam int FRAME_PTR = 2;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;
	localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
	localparam logic [7:0] INDEX_LIMIT = 8'h5f;
	localparam int DATA_SPACE_BYTES = 4096;
	// ==========================================================
	// Reset values and program counter steps.
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [11:0] PTR_RESET = 12'h000;
	localparam logic [20:0] PC_RESET = 21'h00_0000;
	localparam logic [20:0] PC_ONE_WORD = 21'h00_0002;
	localparam logic [20:0] PC_TWO_WORDS = 21'h00_0004;
	// ==========================================================
	// Types.
	typedef enum logic [3:0] {
		OP_NONE, OP_XOR, OP_PTR_ADD, OP_PTR_SUB, OP_FRAME_ADD_RET, OP_FRAME_SUB_RET,
		OP_CALL_ACC, OP_MOVE_TO_FILE, OP_MOVE_TO_INDEXED, OP_PUSH
	} op_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} state_t;
endpackage

// ===== hdl/op_decoder.sv
// Instruction word decoder for the exclusive-OR and extended instruction unit.
`timescale 1ns/1ps
module op_decoder
	import xor_ext_pkg::*;
(
	input wire logic [15:0] word1,
	input wire logic [15:0] word2,
	input wire logic ext_en,
	output op_t op,
	output logic illegal
);
	// ==========================================================
	// Decode. Words outside this unit's set decode as no operation.
	always_comb begin
		op = OP_NONE;
		illegal = 1'b0;
		if (word1[15:10] == XOR_PREFIX) begin
			op = OP_XOR;
		end else if (word1 == OPC_CALL_ACC) begin
			if (ext_en) begin
				op = OP_CALL_ACC;
			end else begin
				illegal = 1'b1;
			end
		end else if (word1[15:10] == OPC_PTR_ADD[7:2]) begin
			if (!ext_en) begin
				illegal = 1'b1;
			end else begin
				case (word1[15:8])
					OPC_PTR_ADD: op = (word1[7:6] == FRAME_SELECT) ? OP_FRAME_ADD_RET : OP_PTR_ADD;
					OPC_PTR_SUB: op = (word1[7:6] == FRAME_SELECT) ? OP_FRAME_SUB_RET : OP_PTR_SUB;
					OPC_PUSH: op = OP_PUSH;
					// Two-word moves need the second-word prefix.
					OPC_MOVE: begin
						if (word2[15:12] != SECOND_WORD_PREFIX) begin
							illegal = 1'b1;
						end else begin
							op = word1[7] ? OP_MOVE_TO_INDEXED : OP_MOVE_TO_FILE;
						end
					end
					default: op = OP_NONE;
				endcase
			end
		end
	end
endmodule

// ===== dv/axil_master.sv
// Host-side bus master model that drives the register port.
`timescale 1ns/1ps
module axil_master (
	input wire logic clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// Idle levels at time zero.
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// The first edge keeps a new request apart from the previous release.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		tb = 1'h0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) bready <= 1'h0;
		end
	endtask
	// Values sampled before the edge are the ones the edge sees.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		tr = 1'h0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (!tr) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'h0;
			if (tr) rready <= 1'h0;
		end
	endtask
endmodule

// ===== dv/xor_ext_exec_assertions.sv
// Protocol and timing checker bound to the execution unit.
`timescale 1ns/1ps
module xor_ext_exec_assertions
	import xor_ext_pkg::*;
#(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_WIDTH-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_WIDTH-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Bus channel checks.
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped or changed");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped or changed");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered next cycle");
	bdone_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write response not released");
	rdone_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read response not released");
	err_zero_a: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0000_0000)
		else $error("error read returns data");
	// ==========================================================
	// Instruction timing: one or two cycles, started only by an accepted write.
	busy_len_a: assert property ($rose(busy) |-> ##[1:2] !busy)
		else $error("instruction too long");
	instr_start_a: assert property ($rose(busy) |-> $rose(bvalid))
		else $error("busy without accepted write");
	cover property ($rose(busy) ##1 busy ##1 !busy);
	cover property (rvalid && rresp == RESP_SLVERR);
	cover property (bvalid && bresp == RESP_SLVERR);
endmodule
bind xor_ext_exec xor_ext_exec_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.clk(clk),
	.rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
	.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .busy(busy));

// ===== dv/xor_and_extended_op_decode_tb.sv
// Self-checking bench for the exclusive-OR and extended instruction unit.
`timescale 1ns/1ps
module xor_and_extended_op_decode_tb import xor_ext_pkg::*; ;
	localparam logic [7:0] FP_REG = REG_PTR0 + 8'h08;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, busy;
	int num_errors = 0;
	int total_checks = 0;
	int n;
	always #5 clk = ~clk;
	xor_ext_exec uut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.busy(busy));
	axil_master m (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] v);
		m.wr(a, v, r);
		check(32'(r), 32'(RESP_OKAY));
	endtask
	task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k = '1);
		m.rd(a, d, r);
		check(d & k, e);
	endtask
	task automatic mset(input logic [11:0] a, input logic [7:0] v);
		w(REG_MEM_ADDR, 32'(a));
		w(REG_MEM_DATA, 32'(v));
	endtask
	task automatic mget(input logic [11:0] a, input logic [7:0] e);
		w(REG_MEM_ADDR, 32'(a));
		rdx(REG_MEM_DATA, 32'(e));
	endtask
	// Counts the extra cycles busy stays up once the write is answered.
	task automatic run(input logic [31:0] i, input int extra);
		w(REG_INSTR, i);
		n = 0;
		@(negedge clk);
		while (busy === 1'h1 && n < 4) begin
			n++;
			@(negedge clk);
		end
		check(32'(n), 32'(extra));
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// A hang counts as a mismatch; the tests need well under this span.
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
	// ==========================================================
	// Test sequence.
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		rdx(REG_CTRL, 32'h0000_0001);
		m.rd(8'hfc, d, r);
		check({d[31:2], r}, 32'(RESP_SLVERR));
		m.wr(8'hfc, 32'h0000_0001, r);
		check(32'(r), 32'(RESP_SLVERR));
		w(REG_ACC, 32'h0000_00b5);
		mset(12'hf85, 8'haf);
		run(32'h0000_1a85, 0);
		mget(12'hf85, 8'h1a);
		rdx(REG_ACC, 32'h0000_00b5);
		rdx(REG_STATUS, 32'h0000_0000);
		w(REG_BANK, 32'h0000_0003);
		mset(12'h310, 8'hb5);
		run(32'h0000_1910, 0);
		rdx(REG_ACC, 32'h0000_0000);
		rdx(REG_STATUS, 32'h0000_0002);
		mget(12'h310, 8'hb5);
		w(FP_REG, 32'h0000_0200);
		mset(12'h205, 8'h0f);
		w(REG_ACC, 32'h0000_00f0);
		run(32'h0000_1a05, 0);
		mget(12'h205, 8'hff);
		rdx(REG_STATUS, 32'h0000_0004);
		w(REG_CTRL, 32'h0000_0000);
		mset(12'h005, 8'h0f);
		run(32'h0000_1a05, 0);
		mget(12'h005, 8'hff);
		w(REG_INSTR, 32'h0000_e805);
		rdx(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
		rdx(REG_PTR0, 32'h0000_0000);
		w(REG_CTRL, 32'h0000_0001);
		$display("test xor done");
		for (int i = 0; i < PTR_COUNT; i++) begin
			w(REG_PTR0 + 8'(i * PTR_STRIDE), 32'h0000_03ff);
			run(32'h0000_e823 | 32'(i << 6), 0);
			rdx(REG_PTR0 + 8'(i * PTR_STRIDE), 32'h0000_0422);
			run(32'h0000_e93f | 32'(i << 6), 0);
			rdx(REG_PTR0 + 8'(i * PTR_STRIDE), 32'h0000_03e3);
		end
		rdx(REG_STATUS, 32'h0000_0004);
		$display("test pointer done");
		w(REG_TOS, 32'h0000_1234);
		w(FP_REG, 32'h0000_0100);
		run(32'h0000_e8c5, 1);
		rdx(FP_REG, 32'h0000_0105);
		rdx(REG_PC, 32'h0000_1234);
		w(REG_PC, 32'h0000_0000);
		run(32'h0000_e9c5, 1);
		rdx(FP_REG, 32'h0000_0100);
		rdx(REG_PC, 32'h0000_1234);
		w(REG_PC, 32'h0000_0100);
		w(REG_PC_LATCH, 32'h0000_0010);
		w(REG_ACC, 32'h0000_0006);
		run(32'h0000_0014, 1);
		rdx(REG_PC, 32'h0000_1006);
		rdx(REG_TOS, 32'h0000_0102);
		rdx(REG_STATUS, 32'h0000_0004);
		$display("test return done");
		w(FP_REG, 32'h0000_0300);
		run(32'h0000_ea7e, 0);
		mget(12'h300, 8'h7e);
		rdx(FP_REG, 32'h0000_02ff);
		mset(12'h305, 8'h5a);
		w(REG_PC, 32'h0000_0000);
		run(32'hf123_eb06, 1);
		mget(12'h123, 8'h5a);
		rdx(REG_PC, 32'h0000_0004);
		run(32'hf00b_eb86, 1);
		mget(12'h30a, 8'h5a);
		mset(12'h124, 8'h00);
		w(REG_INSTR, 32'h0124_eb06);
		rdx(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
		mget(12'h124, 8'h00);
		$display("test move done");
		stop_test();
	end
endmodule
